// >>> core/spimsc_core.sv
// Top of the byte-wide serial port core, master or slave
// What this block does
// - Shift bytes MSB first, full duplex
// - Only master starts and clocks transfers
// - Soft select uses the software level bit
// - Phase-zero slave select toggles between bytes
// - Phase bit picks first or second edge
// - Master drives clock at chosen settings
// - Enable and master drop when select low in master
// - Master data write starts shifting
// - Slave shifts loaded byte on master clock
// - Byte end sets done flag, interrupts
// - Done clears by status then data read, or data write in slave
// - Data writes ignored while done unacknowledged
// - Select low in master raises mode fault
// - Fault clears by status read, control write
// - Byte over set done flags overrun
// - Status read clears overrun
// - Write during transfer collides, no interrupt
// - Rate bits pick master divisor
// - One interrupt for done, fault, overrun
`timescale 1ns/1ps
module spimsc_core #(
  parameter int SYNC_STAGES = spimsc_pkg::SYNC_DEPTH
) (
  // System clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Serial clock pin, also link clock in slave mode
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe,
  // Data and select pins
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe,
  input wire logic ss_n_in,
  // Control register write
  input wire logic ctrl_wr,
  input wire logic ctrl_irq_en,
  input wire logic ctrl_port_en,
  input wire logic ctrl_master,
  input wire logic ctrl_cpol,
  input wire logic ctrl_cpha,
  input wire logic [2:0] ctrl_rate,
  // Select management
  input wire logic soft_select_manage,
  input wire logic soft_select_level,
  // Status and data accesses
  input wire logic stat_rd,
  input wire logic data_wr,
  input wire logic [spimsc_pkg::DATA_W-1:0] data_wdata,
  input wire logic data_rd,
  input wire logic cpu_int_mask,
  // Register contents
  output logic [spimsc_pkg::DATA_W-1:0] data_rdata,
  output logic iface_irq_enable,
  output logic port_enable,
  output logic master_select,
  output logic [2:0] clock_rate_bits,
  output logic transfer_done_flag,
  output logic mode_fault_flag,
  output logic overrun_flag,
  output logic write_collision_flag,
  output logic irq_req
);
  import spimsc_pkg::*;

  if (SYNC_STAGES < 2)
  begin : g_chk
    $error("SYNC_STAGES must be at least 2");
  end

  // ==========================================================
  // Synchronisers
  logic [SYNC_STAGES:0] sync_r [4];
  logic [SYNC_STAGES:0] sync_nxt [4];
  logic [3:0] sync_in;
  logic ss_sync, miso_sync, done_edge, slv_active;
  spimsc_link_if lnk ();

  assign sync_in = {lnk.start_tgl, lnk.done_tgl, miso_in, ss_n_in};

  always_comb
  begin
    for (int i = 0; i < 4; i++)
      sync_nxt[i] = {sync_r[i][SYNC_STAGES-1:0], sync_in[i]};
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      for (int i = 0; i < 4; i++)
        sync_r[i] <= '0;
    else
      sync_r <= sync_nxt;
  end

  assign ss_sync = sync_r[0][SYNC_STAGES-1];
  assign miso_sync = sync_r[1][SYNC_STAGES-1];
  assign done_edge = sync_r[2][SYNC_STAGES-1] ^ sync_r[2][SYNC_STAGES];
  assign slv_active = sync_r[3][SYNC_STAGES] ^ sync_r[2][SYNC_STAGES];

  // ==========================================================
  // Register state
  logic irq_en_r, irq_en_nxt, pe_r, pe_nxt, ms_r, ms_nxt;
  logic cpol_r, cpol_nxt, cpha_r, cpha_nxt;
  logic [2:0] rate_r, rate_nxt;
  logic transfer_done_flag_r, transfer_done_flag_nxt, transfer_done_flag_arm_r, transfer_done_flag_arm_nxt;
  logic mode_fault_flag_r, mode_fault_flag_nxt, mode_fault_flag_arm_r, mode_fault_flag_arm_nxt;
  logic ovr_r, ovr_nxt, write_collision_flag_r, write_collision_flag_nxt, write_collision_flag_arm_r, write_collision_flag_arm_nxt;
  logic [7:0] tx_r, tx_nxt, rx_r, rx_nxt;
  logic start_r, start_nxt, irq_r, irq_nxt;
  logic sck_oe_r, sck_oe_nxt, miso_oe_r, miso_oe_nxt;
  logic ss_int, busy, wr_blocked, clr_transfer_done_flag, xfer_done, fault, mst_busy, mst_done;
  logic [7:0] mst_rx;

  // Internal select from pin or from software level
  assign ss_int = soft_select_manage ? soft_select_level : ss_sync;
  assign fault = ms_r && !ss_int;
  assign busy = ms_r ? (mst_busy || start_r) : (slv_active || (pe_r && !ss_int && !cpha_r));
  assign wr_blocked = transfer_done_flag_r && !transfer_done_flag_arm_r;
  assign clr_transfer_done_flag = transfer_done_flag_arm_r && (data_rd || (data_wr && !ms_r));
  assign xfer_done = ms_r ? mst_done : done_edge;

  always_comb
  begin
    irq_en_nxt = irq_en_r;
    pe_nxt = pe_r;
    ms_nxt = ms_r;
    cpol_nxt = cpol_r;
    cpha_nxt = cpha_r;
    rate_nxt = rate_r;
    mode_fault_flag_nxt = mode_fault_flag_r || fault;
    mode_fault_flag_arm_nxt = mode_fault_flag_arm_r || (stat_rd && mode_fault_flag_r);
    if (ctrl_wr)
    begin
      irq_en_nxt = ctrl_irq_en;
      cpol_nxt = ctrl_cpol;
      cpha_nxt = ctrl_cpha;
      rate_nxt = ctrl_rate;
      pe_nxt = ctrl_port_en;
      ms_nxt = ctrl_master;
      if (mode_fault_flag_r && !mode_fault_flag_arm_r)
      begin
        pe_nxt = 1'b0;
        ms_nxt = 1'b0;
      end
      if (mode_fault_flag_arm_r && !fault)
      begin
        mode_fault_flag_nxt = 1'b0;
        mode_fault_flag_arm_nxt = 1'b0;
      end
    end
    if (fault)
    begin
      pe_nxt = 1'b0;
      ms_nxt = 1'b0;
    end
    // Done flag: a new byte wins over a clear
    transfer_done_flag_nxt = xfer_done || (transfer_done_flag_r && !clr_transfer_done_flag);
    transfer_done_flag_arm_nxt = (transfer_done_flag_arm_r || (stat_rd && transfer_done_flag_r)) && !clr_transfer_done_flag;
    ovr_nxt = (xfer_done && transfer_done_flag_r && !clr_transfer_done_flag) || (ovr_r && !stat_rd);
    rx_nxt = rx_r;
    if (xfer_done && !(transfer_done_flag_r && !clr_transfer_done_flag))
      rx_nxt = ms_r ? mst_rx : lnk.rx_hold;
    tx_nxt = tx_r;
    start_nxt = 1'b0;
    write_collision_flag_nxt = write_collision_flag_r && !(write_collision_flag_arm_r && data_rd);
    write_collision_flag_arm_nxt = (write_collision_flag_arm_r || (stat_rd && write_collision_flag_r)) && !(write_collision_flag_arm_r && data_rd);
    if (data_wr && !wr_blocked)
    begin
      if (busy)
        write_collision_flag_nxt = 1'b1;
      else
      begin
        tx_nxt = data_wdata;
        start_nxt = ms_r && pe_r;
      end
    end
    irq_nxt = irq_en_r && (transfer_done_flag_r || mode_fault_flag_r || ovr_r) && !cpu_int_mask;
    sck_oe_nxt = pe_nxt && ms_nxt;
    miso_oe_nxt = pe_nxt && !ms_nxt && !ss_int;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_en_r <= 1'b0;
      pe_r <= 1'b0;
      ms_r <= 1'b0;
      cpol_r <= 1'b0;
      cpha_r <= 1'b0;
      rate_r <= RATE_RESET;
      transfer_done_flag_r <= 1'b0;
      transfer_done_flag_arm_r <= 1'b0;
      mode_fault_flag_r <= 1'b0;
      mode_fault_flag_arm_r <= 1'b0;
      ovr_r <= 1'b0;
      write_collision_flag_r <= 1'b0;
      write_collision_flag_arm_r <= 1'b0;
      tx_r <= DATA_RESET;
      rx_r <= DATA_RESET;
      start_r <= 1'b0;
      irq_r <= 1'b0;
      sck_oe_r <= 1'b0;
      miso_oe_r <= 1'b0;
    end
    else
    begin
      irq_en_r <= irq_en_nxt;
      pe_r <= pe_nxt;
      ms_r <= ms_nxt;
      cpol_r <= cpol_nxt;
      cpha_r <= cpha_nxt;
      rate_r <= rate_nxt;
      transfer_done_flag_r <= transfer_done_flag_nxt;
      transfer_done_flag_arm_r <= transfer_done_flag_arm_nxt;
      mode_fault_flag_r <= mode_fault_flag_nxt;
      mode_fault_flag_arm_r <= mode_fault_flag_arm_nxt;
      ovr_r <= ovr_nxt;
      write_collision_flag_r <= write_collision_flag_nxt;
      write_collision_flag_arm_r <= write_collision_flag_arm_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
      start_r <= start_nxt;
      irq_r <= irq_nxt;
      sck_oe_r <= sck_oe_nxt;
      miso_oe_r <= miso_oe_nxt;
    end
  end

  // ==========================================================
  // Shifters
  assign lnk.tx_byte = tx_r;
  assign lnk.cpol = cpol_r;
  assign lnk.cpha = cpha_r;
  assign lnk.run = pe_r && !ms_r;

  spimsc_master_shift u_mst (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .start(start_r),
    .tx_byte(tx_r),
    .cpol(cpol_r),
    .cpha(cpha_r),
    .rate(rate_r),
    .miso_sync(miso_sync),
    .busy(mst_busy),
    .done(mst_done),
    .rx_byte(mst_rx),
    .sck_out(sck_out),
    .mosi_out(mosi_out)
  );

  spimsc_slave_link u_slv (
    .sck_in(sck_in),
    .arst_n(arst_n),
    .sel_n(soft_select_manage ? soft_select_level : ss_n_in),
    .mosi_in(mosi_in),
    .miso_out(miso_out),
    .lnk(lnk)
  );

  // ==========================================================
  // Outputs
  assign sck_oe = sck_oe_r;
  assign mosi_oe = sck_oe_r;
  assign miso_oe = miso_oe_r;
  assign data_rdata = rx_r;
  assign iface_irq_enable = irq_en_r;
  assign port_enable = pe_r;
  assign master_select = ms_r;
  assign clock_rate_bits = rate_r;
  assign transfer_done_flag = transfer_done_flag_r;
  assign mode_fault_flag = mode_fault_flag_r;
  assign overrun_flag = ovr_r;
  assign write_collision_flag = write_collision_flag_r;
  assign irq_req = irq_r;

  // ==========================================================
  // Checks
  property p_ovr_set;
    @(posedge clk_sys) disable iff (!arst_n)
    (xfer_done && transfer_done_flag_r && !clr_transfer_done_flag) |=> (ovr_r && transfer_done_flag_r && rx_r == $past(rx_r));
  endproperty
  a_ovr_set: assert property (p_ovr_set) else $error("overrun not flagged");

  property p_ovr_clr;
    @(posedge clk_sys) disable iff (!arst_n)
    (stat_rd && !(xfer_done && transfer_done_flag_r && !clr_transfer_done_flag)) |=> !ovr_r;
  endproperty
  a_ovr_clr: assert property (p_ovr_clr) else $error("overrun not cleared");

  property p_mode_fault_flag;
    @(posedge clk_sys) disable iff (!arst_n)
    fault |=> (mode_fault_flag_r && !pe_r && !ms_r);
  endproperty
  a_mode_fault_flag: assert property (p_mode_fault_flag) else $error("mode fault not handled");

  property p_mode_fault_flag_lock;
    @(posedge clk_sys) disable iff (!arst_n)
    (mode_fault_flag_r && !mode_fault_flag_arm_r) |=> (!pe_r && !ms_r);
  endproperty
  a_mode_fault_flag_lock: assert property (p_mode_fault_flag_lock) else $error("enable set during fault");

  property p_write_collision_flag;
    @(posedge clk_sys) disable iff (!arst_n)
    (data_wr && !wr_blocked && busy) |=> (write_collision_flag_r && tx_r == $past(tx_r) && !start_r);
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("collision not flagged");

  property p_inhibit;
    @(posedge clk_sys) disable iff (!arst_n)
    (data_wr && wr_blocked) |=> (tx_r == $past(tx_r) && !start_r);
  endproperty
  a_inhibit: assert property (p_inhibit) else $error("write not inhibited");

  property p_transfer_done_flag_hold;
    @(posedge clk_sys) disable iff (!arst_n)
    (transfer_done_flag_r && !transfer_done_flag_arm_r) |=> transfer_done_flag_r;
  endproperty
  a_transfer_done_flag_hold: assert property (p_transfer_done_flag_hold) else $error("done flag cleared early");

  property p_irq;
    @(posedge clk_sys) disable iff (!arst_n)
    ##1 irq_r == $past(irq_en_r && (transfer_done_flag_r || mode_fault_flag_r || ovr_r) && !cpu_int_mask);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt mismatch");
endmodule

// >>> shared/spimsc_pkg.sv
// Shared constants, types and rate decoding for the serial port core
package spimsc_pkg;
  localparam int DATA_W = 8;
  localparam int SYNC_DEPTH = 2;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [2:0] RATE_RESET = 3'h0;
  // Rate bit codes, high bit to low
  localparam logic [2:0] RATE_DIV4 = 3'h4;
  localparam logic [2:0] RATE_DIV8 = 3'h0;
  localparam logic [2:0] RATE_DIV16 = 3'h1;
  localparam logic [2:0] RATE_DIV32 = 3'h6;
  localparam logic [2:0] RATE_DIV64 = 3'h2;
  localparam logic [2:0] RATE_DIV128 = 3'h3;
  // Half serial clock periods in system clocks
  localparam logic [6:0] HALF_DIV4 = 7'h02;
  localparam logic [6:0] HALF_DIV8 = 7'h04;
  localparam logic [6:0] HALF_DIV16 = 7'h08;
  localparam logic [6:0] HALF_DIV32 = 7'h10;
  localparam logic [6:0] HALF_DIV64 = 7'h20;
  localparam logic [6:0] HALF_DIV128 = 7'h40;
  // Half-period ticks of one master byte
  localparam logic [4:0] TICK_ZERO = 5'h00;
  localparam logic [4:0] TICK_FIRST = 5'h01;
  localparam logic [4:0] TICK_SCK_END = 5'h10;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;

  typedef enum logic [0:0] {
    MS_IDLE = 1'b0,
    MS_RUN = 1'b1
  } spimsc_mstate_type;

  function automatic logic [6:0] half_period(input logic [2:0] rate);
    logic [6:0] h;
    h = HALF_DIV8;
    case (rate)
      RATE_DIV4: h = HALF_DIV4;
      RATE_DIV16: h = HALF_DIV16;
      RATE_DIV32: h = HALF_DIV32;
      RATE_DIV64: h = HALF_DIV64;
      RATE_DIV128: h = HALF_DIV128;
      default: h = HALF_DIV8;
    endcase
    return h;
  endfunction
endpackage

// >>> shared/spimsc_link_if.sv
// Signals between the system-clock control and the slave link logic
`timescale 1ns/1ps
interface spimsc_link_if;
  logic [7:0] tx_byte;
  logic cpol;
  logic cpha;
  logic run;
  logic [7:0] rx_hold;
  logic done_tgl;
  logic start_tgl;
  modport ctl (output tx_byte, cpol, cpha, run, input rx_hold, done_tgl, start_tgl);
  modport link (input tx_byte, cpol, cpha, run, output rx_hold, done_tgl, start_tgl);
endinterface

// >>> core/spimsc_slave_link.sv
// Slave shifter clocked by the serial clock from the far master
`timescale 1ns/1ps
module spimsc_slave_link (
  // Link clock, reset and select
  input wire logic sck_in,
  input wire logic arst_n,
  input wire logic sel_n,
  // Serial data
  input wire logic mosi_in,
  output logic miso_out,
  // Control side
  spimsc_link_if.link lnk
);
  import spimsc_pkg::*;

  logic sck_eff;
  logic lrst_n;
  logic [2:0] cnt_r, cnt_nxt;
  logic [7:0] rx_r, rx_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic done_r, done_nxt;
  logic start_r, start_nxt;
  logic out_r, out_nxt;

  // Capture on the rising edge of the phase-corrected clock
  assign sck_eff = sck_in ^ lnk.cpol ^ lnk.cpha;
  // Bit count restarts whenever select goes high, the port is off or the port is master
  assign lrst_n = arst_n & lnk.run & ~sel_n;

  always_comb
  begin
    cnt_nxt = cnt_r + 3'h1;
    rx_nxt = {rx_r[6:0], mosi_in};
    hold_nxt = (cnt_r == BIT_LAST) ? rx_nxt : hold_r;
    done_nxt = done_r ^ (cnt_r == BIT_LAST);
    start_nxt = start_r ^ (cnt_r == BIT_FIRST);
    out_nxt = lnk.tx_byte[BIT_LAST - cnt_r];
  end

  always_ff @(posedge sck_eff or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      cnt_r <= BIT_FIRST;
      rx_r <= DATA_RESET;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      rx_r <= rx_nxt;
    end
  end

  always_ff @(posedge sck_eff or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hold_r <= DATA_RESET;
      done_r <= 1'b0;
      start_r <= 1'b0;
    end
    else if (lrst_n)
    begin
      hold_r <= hold_nxt;
      done_r <= done_nxt;
      start_r <= start_nxt;
    end
  end

  always_ff @(negedge sck_eff or negedge lrst_n)
  begin
    if (!lrst_n)
      out_r <= 1'b0;
    else
      out_r <= out_nxt;
  end

  // First bit is on the line before the first edge
  assign miso_out = (cnt_r == BIT_FIRST) ? lnk.tx_byte[BIT_LAST] : out_r;
  assign lnk.rx_hold = hold_r;
  assign lnk.done_tgl = done_r;
  assign lnk.start_tgl = start_r;
endmodule

// >>> core/spimsc_master_shift.sv
// Master byte shifter with serial clock divider
`timescale 1ns/1ps
module spimsc_master_shift (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // Transfer request
  input wire logic start,
  input wire logic [spimsc_pkg::DATA_W-1:0] tx_byte,
  input wire logic cpol,
  input wire logic cpha,
  input wire logic [2:0] rate,
  input wire logic miso_sync,
  // Transfer result
  output logic busy,
  output logic done,
  output logic [spimsc_pkg::DATA_W-1:0] rx_byte,
  // Link
  output logic sck_out,
  output logic mosi_out
);
  import spimsc_pkg::*;

  spimsc_mstate_type st_r, st_nxt;
  logic [6:0] div_r, div_nxt;
  logic [4:0] tick_r, tick_nxt;
  logic sck_r, sck_nxt;
  logic mosi_r, mosi_nxt;
  logic done_r, done_nxt;
  logic [7:0] tx_r, tx_nxt;
  logic [7:0] rx_r, rx_nxt;

  always_comb
  begin
    logic [4:0] t;
    t = tick_r + TICK_FIRST;
    st_nxt = st_r;
    div_nxt = div_r;
    tick_nxt = tick_r;
    sck_nxt = sck_r;
    mosi_nxt = mosi_r;
    done_nxt = 1'b0;
    tx_nxt = tx_r;
    rx_nxt = rx_r;
    unique case (st_r)
      MS_IDLE:
      begin
        sck_nxt = cpol;
        if (start)
        begin
          st_nxt = MS_RUN;
          div_nxt = half_period(rate) - 7'h01;
          tick_nxt = TICK_ZERO;
          tx_nxt = tx_byte;
          if (!cpha)
          begin
            mosi_nxt = tx_byte[7];
            tx_nxt = tx_byte << 1;
          end
        end
      end
      MS_RUN:
      begin
        if (div_r != 7'h00)
          div_nxt = div_r - 7'h01;
        else
        begin
          div_nxt = half_period(rate) - 7'h01;
          tick_nxt = t;
          if (t <= TICK_SCK_END)
            sck_nxt = ~sck_r;
          if ((t[0] == cpha) && (t < TICK_SCK_END))
          begin
            mosi_nxt = tx_r[7];
            tx_nxt = tx_r << 1;
          end
          // Sample half a period after each capture edge
          if ((t[0] == cpha) && !(cpha && (t == TICK_FIRST)))
            rx_nxt = {rx_r[6:0], miso_sync};
          if (t == (TICK_SCK_END + {4'h0, cpha}))
          begin
            st_nxt = MS_IDLE;
            done_nxt = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= MS_IDLE;
      div_r <= 7'h00;
      tick_r <= TICK_ZERO;
      sck_r <= 1'b0;
      mosi_r <= 1'b0;
      done_r <= 1'b0;
      tx_r <= DATA_RESET;
      rx_r <= DATA_RESET;
    end
    else
    begin
      st_r <= st_nxt;
      div_r <= div_nxt;
      tick_r <= tick_nxt;
      sck_r <= sck_nxt;
      mosi_r <= mosi_nxt;
      done_r <= done_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign busy = (st_r == MS_RUN);
  assign done = done_r;
  assign rx_byte = rx_r;
  assign sck_out = sck_r;
  assign mosi_out = mosi_r;

  property p_sck_idle;
    @(posedge clk_sys) disable iff (!arst_n)
    (st_r == MS_IDLE && !start) |=> (sck_r == $past(cpol));
  endproperty
  a_sck_idle: assert property (p_sck_idle) else $error("sck not at idle level");

  property p_msb_first;
    @(posedge clk_sys) disable iff (!arst_n)
    (st_r == MS_IDLE && start && !cpha) |=> (mosi_r == $past(tx_byte[7]) && st_r == MS_RUN);
  endproperty
  a_msb_first: assert property (p_msb_first) else $error("first bit not msb");
endmodule

// >>> testbench/spimsc_far_node.sv
// Far serial node model: slave responder and link-clock master
`timescale 1ns/1ps
module spimsc_far_node (
  // Link lines as resolved on the wire
  input wire logic sck_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  input wire logic cpol,
  input wire logic cpha,
  // Far-side drives
  output logic sck_far,
  output logic mosi_far,
  output logic miso_far,
  output logic ss_far_n
);
  logic [7:0] sh = 8'h00;
  logic [7:0] rx = 8'h00;
  logic act = 1'b0;
  int n = 0;
  wire ed = sck_w ^ cpol ^ cpha;
  initial
  begin
    sck_far = 1'b0;
    mosi_far = 1'b0;
    ss_far_n = 1'b1;
  end
  // ====
  // Slave role
  always @(posedge ed)
  begin
    if (act)
      rx <= {rx[6:0], mosi_w};
  end
  always @(negedge ed)
  begin
    n <= n + 1;
  end
  assign miso_far = (act && n >= cpha && n < 8 + cpha) ? sh[7 - (n - cpha)] : ~sh[0];
  task automatic load(input logic [7:0] b);
    sh = b;
    rx = 8'h00;
    n = 0;
    act = 1'b1;
  endtask
  task automatic set_ss(input logic v);
    ss_far_n = v;
  endtask
  // ====
  // Master role, 30 ns link clock only within frames
  always @(cpol)
  begin
    if (ss_far_n)
      sck_far = cpol;
  end
  task automatic drive_byte(input logic [7:0] b, output logic [7:0] r);
    #3;
    sck_far = cpol;
    ss_far_n = 1'b0;
    mosi_far = b[7];
    #60;
    for (int i = 0; i < 8; i++)
    begin
      if (cpha)
      begin
        sck_far = ~sck_far;
        mosi_far = b[7 - i];
        #15;
      end
      sck_far = ~sck_far;
      r = {r[6:0], miso_w};
      #15;
      if (!cpha)
      begin
        sck_far = ~sck_far;
        mosi_far = (i < 7) ? b[6 - i] : ~b[0];
        #15;
      end
    end
    #15;
    ss_far_n = 1'b1;
    mosi_far = ~mosi_far;
  endtask
endmodule

// >>> testbench/spimsc_core_test.sv
// Self-checking bench for the serial port core
`timescale 1ns/1ps
module spimsc_core_test;
  import spimsc_pkg::*;
  localparam logic [3:0] OP_CTRL = 4'h8;
  localparam logic [3:0] OP_STAT = 4'h4;
  localparam logic [3:0] OP_WR = 4'h2;
  localparam logic [3:0] OP_RD = 4'h1;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic ctrl_wr = 1'b0;
  logic ctrl_irq_en = 1'b1;
  logic ctrl_port_en = 1'b0;
  logic ctrl_master = 1'b0;
  logic ctrl_cpol = 1'b0;
  logic ctrl_cpha = 1'b0;
  logic [2:0] ctrl_rate = 3'h0;
  logic soft_select_manage = 1'b1;
  logic soft_select_level = 1'b1;
  logic stat_rd = 1'b0;
  logic data_wr = 1'b0;
  logic data_rd = 1'b0;
  logic [7:0] data_wdata = 8'h00;
  logic cpu_int_mask = 1'b0;
  logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe;
  logic iface_irq_enable, port_enable, master_select, irq_req;
  logic transfer_done_flag, mode_fault_flag, overrun_flag, write_collision_flag;
  logic [7:0] data_rdata;
  logic [2:0] clock_rate_bits;
  logic sck_far, mosi_far, miso_far, ss_far_n;
  wire sck_w = sck_oe ? sck_out : sck_far;
  wire mosi_w = mosi_oe ? mosi_out : mosi_far;
  wire miso_w = miso_oe ? miso_out : miso_far;
  logic [2:0] rates [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  logic [7:0] tx, sx, got;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  int seed = 99;
  spimsc_core #(.SYNC_STAGES(2)) i_dut (
    .clk_sys, .arst_n, .sck_in(sck_w), .sck_out, .sck_oe,
    .mosi_in(mosi_w), .mosi_out, .mosi_oe, .miso_in(miso_w), .miso_out, .miso_oe,
    .ss_n_in(ss_far_n), .ctrl_wr, .ctrl_irq_en, .ctrl_port_en, .ctrl_master,
    .ctrl_cpol, .ctrl_cpha, .ctrl_rate, .soft_select_manage, .soft_select_level,
    .stat_rd, .data_wr, .data_wdata, .data_rd, .cpu_int_mask, .data_rdata,
    .iface_irq_enable, .port_enable, .master_select, .clock_rate_bits,
    .transfer_done_flag, .mode_fault_flag, .overrun_flag, .write_collision_flag,
    .irq_req
  );
  spimsc_far_node i_far (
    .sck_w, .mosi_w, .miso_w, .cpol(ctrl_cpol), .cpha(ctrl_cpha),
    .sck_far, .mosi_far, .miso_far, .ss_far_n
  );
  always #5 clk_sys = ~clk_sys;
  // Ceiling well above the slowest rate sweep
  always @(posedge clk_sys)
  begin
    cycles <= cycles + 1;
    if (cycles == 60000)
    begin
      fails++;
      close_out();
    end
  end
  // ====
  // Shared tasks
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic op(input logic [3:0] m);
    @(negedge clk_sys);
    {ctrl_wr, stat_rd, data_wr, data_rd} = m;
    @(negedge clk_sys);
    {ctrl_wr, stat_rd, data_wr, data_rd} = 4'h0;
    @(negedge clk_sys);
  endtask
  task automatic cfg(input logic e, input logic m);
    ctrl_port_en = 1'b0;
    ctrl_master = 1'b0;
    op(OP_CTRL);
    ctrl_port_en = e;
    ctrl_master = m;
    op(OP_CTRL);
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && transfer_done_flag !== 1'b1; i++)
      @(negedge clk_sys);
    // Interrupt request follows the flag by one cycle
    @(negedge clk_sys);
  endtask
  task automatic half_count(output int c);
    logic s;
    c = 0;
    for (int i = 0; i < 500 && sck_out === ctrl_cpol; i++)
      @(negedge clk_sys);
    s = sck_out;
    while (sck_out === s && c < 500)
    begin
      @(negedge clk_sys);
      c++;
    end
  endtask
  function automatic int exp_half(input logic [2:0] r);
    case (r)
      3'h4: return 2;
      3'h0: return 4;
      3'h1: return 8;
      3'h6: return 16;
      3'h2: return 32;
      default: return 64;
    endcase
  endfunction
  // ====
  // Main sequence
  initial
  begin
    int c;
    repeat (12) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    repeat (4) @(negedge clk_sys);
    check("done_rst", transfer_done_flag, 1'b0);
    for (int k = 0; k < 12; k++)
    begin
      ctrl_rate = rates[k % 6];
      {ctrl_cpol, ctrl_cpha} = k[1:0];
      cfg(1'b1, 1'b1);
      tx = (k == 0) ? 8'h01 : 8'($random(seed));
      sx = (k == 0) ? 8'h80 : 8'($random(seed));
      i_far.load(sx);
      i_far.set_ss(k[0]);
      data_wdata = tx;
      op(OP_WR);
      check("sck_oe", sck_oe, 1'b1);
      check("mosi_oe", mosi_oe, 1'b1);
      check("rate", clock_rate_bits, ctrl_rate);
      half_count(c);
      check("half", c[7:0], 8'(exp_half(ctrl_rate)));
      wait_done();
      check("done", transfer_done_flag, 1'b1);
      check("irq", irq_req, 1'b1);
      check("far_rx", i_far.rx, tx);
      check("rdata", data_rdata, sx);
      check("fault", mode_fault_flag, 1'b0);
      check("sck_idle", sck_out, ctrl_cpol);
      op(OP_STAT);
      op(OP_RD);
      check("done_clr", transfer_done_flag, 1'b0);
    end
    // ====
    // Collision, ignored write and overrun
    ctrl_rate = 3'h4;
    {ctrl_cpol, ctrl_cpha} = 2'h0;
    cfg(1'b1, 1'b1);
    i_far.load(8'ha5);
    data_wdata = 8'h3c;
    op(OP_WR);
    data_wdata = 8'hff;
    op(OP_WR);
    check("write_collision_flag", write_collision_flag, 1'b1);
    check("irq_write_collision_flag", irq_req, 1'b0);
    wait_done();
    check("far_keep", i_far.rx, 8'h3c);
    i_far.load(8'h5a);
    op(OP_WR);
    repeat (40) @(negedge clk_sys);
    check("ignored", i_far.rx, 8'h00);
    op(OP_STAT);
    data_wdata = 8'hc3;
    op(OP_WR);
    repeat (50) @(negedge clk_sys);
    check("ovr", overrun_flag, 1'b1);
    check("ovr_keep", data_rdata, 8'ha5);
    check("far_ovr", i_far.rx, 8'hc3);
    op(OP_STAT);
    check("ovr_clr", overrun_flag, 1'b0);
    op(OP_RD);
    check("done_clr2", transfer_done_flag, 1'b0);
    check("write_collision_flag_clr", write_collision_flag, 1'b0);
    // ====
    // Mode fault from the select pin
    soft_select_manage = 1'b0;
    i_far.set_ss(1'b0);
    repeat (6) @(negedge clk_sys);
    check("mode_fault_flag", mode_fault_flag, 1'b1);
    check("pe_drop", port_enable, 1'b0);
    check("ms_drop", master_select, 1'b0);
    check("irq_mode_fault_flag", irq_req, 1'b1);
    cpu_int_mask = 1'b1;
    repeat (2) @(negedge clk_sys);
    check("irq_mask", irq_req, 1'b0);
    i_far.set_ss(1'b1);
    repeat (4) @(negedge clk_sys);
    op(OP_CTRL);
    check("pe_refused", port_enable, 1'b0);
    check("mode_fault_flag_kept", mode_fault_flag, 1'b1);
    op(OP_STAT);
    op(OP_CTRL);
    check("mode_fault_flag_clr", mode_fault_flag, 1'b0);
    check("pe_back", port_enable, 1'b1);
    cpu_int_mask = 1'b0;
    // ====
    // Slave bytes in both phases
    for (int k = 0; k < 2; k++)
    begin
      ctrl_cpha = k[0];
      ctrl_cpol = 1'($random(seed));
      cfg(1'b1, 1'b0);
      tx = 8'($random(seed));
      sx = 8'($random(seed));
      data_wdata = tx;
      op(OP_WR);
      i_far.drive_byte(sx, got);
      repeat (8) @(negedge clk_sys);
      check("s_done", transfer_done_flag, 1'b1);
      check("s_rdata", data_rdata, sx);
      check("s_tx", got, tx);
      op(OP_STAT);
      op(OP_WR);
      check("s_clr", transfer_done_flag, 1'b0);
    end
    ctrl_cpha = 1'b0;
    cfg(1'b1, 1'b0);
    i_far.set_ss(1'b0);
    repeat (4) @(negedge clk_sys);
    op(OP_WR);
    check("s_write_collision_flag", write_collision_flag, 1'b1);
    check("miso_oe", miso_oe, 1'b1);
    i_far.set_ss(1'b1);
    op(OP_STAT);
    op(OP_RD);
    check("s_write_collision_flag_clr", write_collision_flag, 1'b0);
    // ====
    // Soft select level dropped in master, interrupt disabled
    soft_select_manage = 1'b1;
    ctrl_irq_en = 1'b0;
    cfg(1'b1, 1'b1);
    check("irq_en", iface_irq_enable, 1'b0);
    soft_select_level = 1'b0;
    repeat (3) @(negedge clk_sys);
    check("soft_mode_fault_flag", mode_fault_flag, 1'b1);
    check("soft_pe_drop", port_enable, 1'b0);
    check("irq_off", irq_req, 1'b0);
    close_out();
  end
endmodule
